//--- wfa_adc.sv
`timescale 1ns/1ps
// Converter model: one result per request, only when the block is ready
module wfa_adc (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic conv_ready,
  input wire logic go,
  input wire logic [23:0] val,
  output wfa_pkg::wfa_rdg_t conv
);
  logic pend_r;
  logic [23:0] hold_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
      hold_r <= 24'h000000;
      conv <= '0;
    end else begin
      if (go) begin
        pend_r <= 1'b1;
        hold_r <= val;
      end
      // Waits out the analog settling time before converting
      if (pend_r && conv_ready && !conv.valid && !go) begin
        conv.valid <= 1'b1;
        conv.data <= hold_r;
        pend_r <= 1'b0;
      end else begin
        conv.valid <= 1'b0;
        // Idle data inverts each cycle, so it repeats the last result every second cycle
        conv.data <= ~conv.data;
      end
    end
  end
endmodule : wfa_adc

//--- wfa_filter.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// What this block does
// - Enable and configuration kept per function
// - Analog stage adds 125 ms between conversions
// - Output averages count conversions, 1 to 100
// - Count one: no average, window still applies
// - Out-of-window conversion restarts from that value
// - Window 0.01 to 10.23 percent or none
// - Voltage window is percent of range
// - Temperature window is percent of thermocouple maximum
// - Moving stack evicts oldest, new reading each
// - Repeating stack fills, averages once, then clears
// - Delta forces moving mode
// - Stepping or scanning forces repeating mode unless delta is set
// - Moving restart loads whole stack; outputs value only when count is above one
// - Unsettled blinking until stack refilled; readings flow
// - Settled sets operation event bit 8
// - Key toggles enable; indicator shows enable
// - Config applies now if enabled, else later
// - Both stages off on enable: digital on
// - Function or range change resets filter
// - Ratio uses first voltage channel settings
module wfa_filter #(
  parameter int SETTLE_CYC = wfa_pkg::SETTLE_CYC,
  parameter int BLINK_CYC = wfa_pkg::BLINK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [wfa_pkg::AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire wfa_pkg::wfa_rdg_t conv,
  output logic conv_ready,
  output wfa_pkg::wfa_rdg_t rdg,
  output logic lpass_on,
  output logic settled,
  output logic indicator
);
  localparam int DW = wfa_pkg::DW;
  localparam int SW = wfa_pkg::SW;

  function automatic logic [6:0] cnt_fix(input logic [6:0] c);
    if (c < wfa_pkg::CNT_MIN) return wfa_pkg::CNT_MIN;
    if (c > wfa_pkg::CNT_MAX) return wfa_pkg::CNT_MAX;
    return c;
  endfunction : cnt_fix

  function automatic logic signed [DW-1:0] avg(
    input logic signed [SW-1:0] s, input logic [6:0] n);
    logic signed [SW-1:0] q;
    q = s / $signed({25'h0, n});
    return q[DW-1:0];
  endfunction : avg

  function automatic logic [6:0] adv(input logic [6:0] p,
                                     input logic [6:0] n);
    return (p + 7'h01 >= n) ? 7'h00 : p + 7'h01;
  endfunction : adv

  // Register group
  wfa_pkg::wfa_cfg_t cfg_r [4];
  wfa_pkg::wfa_cfg_t cfg_nxt [4];
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [31:0] fs_r, fs_nxt;
  logic [31:0] tc_r, tc_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic restart;

  // Filter group
  logic signed [DW-1:0] stk_r [wfa_pkg::DEPTH];
  logic signed [DW-1:0] stk_nxt [wfa_pkg::DEPTH];
  logic signed [SW-1:0] sum_r, sum_nxt;
  logic [6:0] fill_r, fill_nxt, ptr_r, ptr_nxt, fresh_r, fresh_nxt;
  logic signed [DW-1:0] ref_r, ref_nxt;
  logic have_r, have_nxt;
  logic settled_r, settled_nxt;
  logic ev_r, ev_nxt;
  logic ind_r, ind_nxt;
  logic blink_r, blink_nxt;
  logic [31:0] bcnt_r, bcnt_nxt;
  logic [31:0] wait_r, wait_nxt;
  wfa_pkg::wfa_rdg_t rdg_r, rdg_nxt;

  // Effective selection
  wfa_pkg::wfa_func_t sel;
  wfa_pkg::wfa_cfg_t act;
  wfa_pkg::wfa_mode_t mode;
  logic [6:0] n;
  logic act_en, dig, ana, inwin;
  logic [31:0] fs_eff;
  logic signed [SW-1:0] hw, diff;
  logic [1:0] cidx;
  logic cfg_hit;

  assign sel = ctrl_r[wfa_pkg::C_RATIO] ?
               wfa_pkg::wfa_voltage_channel_one :
               wfa_pkg::wfa_func_t'(ctrl_r[1:0]);
  assign act = cfg_r[sel];
  assign act_en = act.en;
  assign dig = act.en & act.dfilt;
  assign ana = act.en & act.lpass;
  assign mode = ctrl_r[wfa_pkg::C_DELTA] ? wfa_pkg::wfa_moving :
                ctrl_r[wfa_pkg::C_SCAN] ? wfa_pkg::wfa_repeat :
                act.mode;
  assign n = cnt_fix(act.cnt);
  assign fs_eff = sel[1] ? tc_r : fs_r;
  // Wide product keeps full scale times window from overflowing
  assign hw = SW'((64'(fs_eff) * 64'(act.win)) / wfa_pkg::WIN_DIV);
  assign diff = SW'(conv.data) - SW'(ref_r);
  assign inwin = !have_r || act.win == wfa_pkg::WIN_NONE ||
                 (diff <= hw && diff >= -hw);
  assign cidx = addr[3:2];
  assign cfg_hit = addr[7:4] == wfa_pkg::A_CFG_HI;

  assign rdata = rdata_r;
  assign rdg = rdg_r;
  assign settled = settled_r;
  assign indicator = ind_r;
  assign lpass_on = ana;
  assign conv_ready = wait_r == 32'h0;

  always_comb begin
    wfa_pkg::wfa_cfg_t c;
    c = cfg_r[cidx];
    cfg_nxt = cfg_r;
    ctrl_nxt = ctrl_r;
    fs_nxt = fs_r;
    tc_nxt = tc_r;
    restart = 1'b0;
    rdata_nxt = 32'h0;
    if (wr) begin
      if (addr == wfa_pkg::A_CTRL) begin
        ctrl_nxt = wdata[4:0];
        restart = wdata[4:0] != ctrl_r;
      end else if (addr == wfa_pkg::A_FS) begin
        fs_nxt = wdata;
        restart = wdata != fs_r;
      end else if (addr == wfa_pkg::A_TCMAX) begin
        tc_nxt = wdata;
        restart = wdata != tc_r;
      end else if (addr == wfa_pkg::A_KEY) begin
        cfg_nxt[sel].en = !act.en;
        if (!act.en && !act.lpass && !act.dfilt) begin
          cfg_nxt[sel].dfilt = 1'b1;
        end
        restart = 1'b1;
      end else if (cfg_hit) begin
        c.lpass = wdata[wfa_pkg::F_LP];
        c.dfilt = wdata[wfa_pkg::F_DF];
        c.mode = wfa_pkg::wfa_mode_t'(wdata[wfa_pkg::F_RPT]);
        c.cnt = wdata[wfa_pkg::F_CNT +: 7];
        c.win = wdata[wfa_pkg::F_WIN +: 10];
        if (c.en && !c.lpass && !c.dfilt) begin
          c.dfilt = 1'b1;
        end
        cfg_nxt[cidx] = c;
        restart = cidx == sel;
      end
    end
    if (rd) begin
      if (addr == wfa_pkg::A_CTRL) begin
        rdata_nxt = {27'h0, ctrl_r};
      end else if (addr == wfa_pkg::A_FS) begin
        rdata_nxt = fs_r;
      end else if (addr == wfa_pkg::A_TCMAX) begin
        rdata_nxt = tc_r;
      end else if (addr == wfa_pkg::A_STAT) begin
        rdata_nxt[wfa_pkg::S_SETTLED] = settled_r;
        rdata_nxt[wfa_pkg::S_IND] = ind_r;
        rdata_nxt[wfa_pkg::S_EN] = act.en;
        rdata_nxt[wfa_pkg::S_OPEV] = ev_r;
      end else if (addr == wfa_pkg::A_READ) begin
        rdata_nxt = SW'(rdg_r.data);
      end else if (cfg_hit) begin
        rdata_nxt[wfa_pkg::F_EN] = c.en;
        rdata_nxt[wfa_pkg::F_LP] = c.lpass;
        rdata_nxt[wfa_pkg::F_DF] = c.dfilt;
        rdata_nxt[wfa_pkg::F_RPT] = c.mode;
        rdata_nxt[wfa_pkg::F_CNT +: 7] = c.cnt;
        rdata_nxt[wfa_pkg::F_WIN +: 10] = c.win;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        cfg_r[i] <= wfa_pkg::CFG_RST;
      end
      ctrl_r <= 5'h00;
      fs_r <= 32'h0;
      tc_r <= 32'h0;
      rdata_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      fs_r <= fs_nxt;
      tc_r <= tc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    stk_nxt = stk_r;
    sum_nxt = sum_r;
    fill_nxt = fill_r;
    ptr_nxt = ptr_r;
    fresh_nxt = fresh_r;
    ref_nxt = ref_r;
    have_nxt = have_r;
    settled_nxt = settled_r;
    rdg_nxt = '{1'b0, rdg_r.data};
    wait_nxt = (wait_r != 32'h0) ? wait_r - 32'h1 : 32'h0;
    bcnt_nxt = bcnt_r + 32'h1;
    blink_nxt = blink_r;
    if (bcnt_r >= 32'(BLINK_CYC - 1)) begin
      bcnt_nxt = 32'h0;
      blink_nxt = !blink_r;
    end
    if (restart) begin
      fill_nxt = 7'h00;
      sum_nxt = '0;
      ptr_nxt = 7'h00;
      fresh_nxt = 7'h00;
      have_nxt = 1'b0;
      settled_nxt = 1'b0;
      wait_nxt = 32'h0;
    end else if (conv.valid) begin
      if (ana) begin
        wait_nxt = 32'(SETTLE_CYC);
      end
      if (!dig) begin
        rdg_nxt = '{1'b1, conv.data};
        settled_nxt = 1'b1;
      end else if (!inwin) begin
        ref_nxt = conv.data;
        fresh_nxt = 7'h01;
        settled_nxt = n == 7'h01;
        if (mode == wfa_pkg::wfa_moving && n != 7'h01) begin
          for (int i = 0; i < wfa_pkg::DEPTH; i++) begin
            if (7'(i) < n) stk_nxt[i] = conv.data;
          end
          // Product taken at full sum width so large counts cannot wrap
          sum_nxt = SW'(conv.data) * SW'(n);
          fill_nxt = n;
          ptr_nxt = 7'h00;
          rdg_nxt = '{1'b1, conv.data};
        end else begin
          stk_nxt[0] = conv.data;
          sum_nxt = SW'(conv.data);
          fill_nxt = 7'h01;
          ptr_nxt = adv(7'h00, n);
          if (mode == wfa_pkg::wfa_repeat && n == 7'h01) begin
            fill_nxt = 7'h00;
            sum_nxt = '0;
          end
        end
      end else begin
        have_nxt = 1'b1;
        if (!have_r) ref_nxt = conv.data;
        if (fresh_r < n) fresh_nxt = fresh_r + 7'h01;
        if (fresh_r + 7'h01 >= n) settled_nxt = 1'b1;
        stk_nxt[ptr_r] = conv.data;
        ptr_nxt = adv(ptr_r, n);
        if (fill_r < n) begin
          sum_nxt = sum_r + SW'(conv.data);
          fill_nxt = fill_r + 7'h01;
          if (fill_r + 7'h01 == n) begin
            rdg_nxt = '{1'b1, avg(sum_nxt, n)};
            ref_nxt = rdg_nxt.data;
            if (mode == wfa_pkg::wfa_repeat) begin
              fill_nxt = 7'h00;
              sum_nxt = '0;
              ptr_nxt = 7'h00;
            end
          end
        end else begin
          sum_nxt = sum_r + SW'(conv.data) - SW'(stk_r[ptr_r]);
          rdg_nxt = '{1'b1, avg(sum_nxt, n)};
          ref_nxt = rdg_nxt.data;
        end
      end
    end
    ev_nxt = ev_r;
    if (rd && addr == wfa_pkg::A_STAT) ev_nxt = 1'b0;
    if (settled_nxt && !settled_r) ev_nxt = 1'b1;
    ind_nxt = act.en && (settled_r || blink_r);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < wfa_pkg::DEPTH; i++) begin
        stk_r[i] <= '0;
      end
      sum_r <= '0;
      fill_r <= 7'h00;
      ptr_r <= 7'h00;
      fresh_r <= 7'h00;
      ref_r <= '0;
      have_r <= 1'b0;
      settled_r <= 1'b0;
      ev_r <= 1'b0;
      ind_r <= 1'b0;
      blink_r <= 1'b0;
      bcnt_r <= 32'h0;
      wait_r <= 32'h0;
      rdg_r <= '0;
    end else begin
      stk_r <= stk_nxt;
      sum_r <= sum_nxt;
      fill_r <= fill_nxt;
      ptr_r <= ptr_nxt;
      fresh_r <= fresh_nxt;
      ref_r <= ref_nxt;
      have_r <= have_nxt;
      settled_r <= settled_nxt;
      ev_r <= ev_nxt;
      ind_r <= ind_nxt;
      blink_r <= blink_nxt;
      bcnt_r <= bcnt_nxt;
      wait_r <= wait_nxt;
      rdg_r <= rdg_nxt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_key;
    wr && addr == wfa_pkg::A_KEY;
  endsequence
  sequence s_take;
    conv.valid && !restart && dig;
  endsequence

  a_key_toggle: assert property (s_key |=> act_en != $past(act_en))
    else $error("filter key did not toggle enable");
  a_auto_digital: assert property (s_key ##0 !act_en |=> dig)
    else $error("digital stage not forced on");
  a_reset_empty: assert property (restart |=> fill_r == 7'h00 && !settled_r)
    else $error("filter not reset");
  a_settle_gap: assert property (conv.valid && ana && !restart
    |=> !conv_ready [*8])
    else $error("conversion allowed during settling");
  a_one_window: assert property (s_take ##0 n == 7'h01 && !inwin
    |=> !rdg_r.valid)
    else $error("out of window reading passed");
  a_moving_load: assert property (s_take ##0 !inwin && n != 7'h01 &&
    mode == wfa_pkg::wfa_moving |=> rdg_r.valid &&
    rdg_r.data == $past(conv.data) && fill_r == $past(n))
    else $error("moving restart not loaded");
  a_moving_evict: assert property (s_take ##0 inwin && fill_r == n &&
    mode == wfa_pkg::wfa_moving |=> rdg_r.valid)
    else $error("moving filter gave no reading");
  a_repeat_clear: assert property (rdg_r.valid && dig &&
    mode == wfa_pkg::wfa_repeat |-> fill_r == 7'h00)
    else $error("repeat stack not cleared");
  a_event_set: assert property (settled_r && !$past(settled_r)
    |-> ev_r)
    else $error("settled event lost");
  a_ind_off: assert property (!act_en |=> !indicator)
    else $error("indicator lit while disabled");
endmodule : wfa_filter

//--- wfa_pkg.sv
package wfa_pkg;
  localparam int DW = 24;
  localparam int SW = 32;
  localparam int DEPTH = 100;
  localparam int AW = 8;
  localparam logic [6:0] CNT_MIN = 7'h01;
  localparam logic [6:0] CNT_MAX = 7'h64;
  // Window in steps of 0.01 %, zero means no window
  localparam logic [9:0] WIN_NONE = 10'h000;
  localparam longint WIN_DIV = 64'h2710;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_MS = 125;
  localparam int BLINK_MS = 250;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;

  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_FS = 8'h04;
  localparam logic [AW-1:0] A_TCMAX = 8'h08;
  localparam logic [AW-1:0] A_KEY = 8'h0C;
  localparam logic [AW-1:0] A_STAT = 8'h10;
  localparam logic [AW-1:0] A_READ = 8'h14;
  localparam logic [3:0] A_CFG_HI = 4'h2;

  localparam int C_RATIO = 2;
  localparam int C_DELTA = 3;
  localparam int C_SCAN = 4;
  localparam int S_SETTLED = 0;
  localparam int S_IND = 1;
  localparam int S_EN = 2;
  localparam int S_OPEV = 8;
  localparam int F_EN = 0;
  localparam int F_LP = 1;
  localparam int F_DF = 2;
  localparam int F_RPT = 3;
  localparam int F_CNT = 4;
  localparam int F_WIN = 16;

  typedef enum logic [1:0] {
    wfa_voltage_channel_one = 2'b00,
    wfa_voltage_channel_two = 2'b01,
    wfa_temperature_channel_one = 2'b10,
    wfa_temperature_channel_two = 2'b11
  } wfa_func_t;

  typedef enum logic {wfa_moving = 1'b0, wfa_repeat = 1'b1} wfa_mode_t;

  typedef struct packed {
    logic en;
    logic lpass;
    logic dfilt;
    wfa_mode_t mode;
    logic [6:0] cnt;
    logic [9:0] win;
  } wfa_cfg_t;

  typedef struct packed {
    logic valid;
    logic signed [DW-1:0] data;
  } wfa_rdg_t;

  localparam wfa_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b1, wfa_moving,
                                   7'h0A, 10'h001};
endpackage : wfa_pkg

//--- windowed_averaging_reading_filter_bench.sv
`timescale 1ns/1ps
module windowed_averaging_reading_filter_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  wfa_pkg::wfa_rdg_t conv;
  wfa_pkg::wfa_rdg_t rdg;
  logic conv_ready, lpass_on, settled, indicator, go = 1'b0;
  logic [23:0] val = 24'h000000;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int lowcnt = 0;
  int lowrun = 0;
  logic [23:0] got[$];
  logic [31:0] d;
  int a, b, x;

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Short settle and blink counts keep the run brief
  wfa_filter #(.SETTLE_CYC(20), .BLINK_CYC(4)) dut (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .conv(conv), .conv_ready(conv_ready),
    .rdg(rdg), .lpass_on(lpass_on), .settled(settled),
    .indicator(indicator)
  );
  wfa_adc adc (.mclk(mclk), .rst_b(rst_b), .conv_ready(conv_ready),
    .go(go), .val(val), .conv(conv));

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rdg.valid === 1'b1) got.push_back(rdg.data);
    if (conv_ready === 1'b0) lowcnt <= lowcnt + 1;
    else if (lowcnt != 0) begin
      lowrun <= lowcnt;
      lowcnt <= 0;
    end
    if (cyc == 20000) begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk_rdg(input logic [23:0] e);
    samples_checked++;
    if (got.size() != 1 || got[0] !== e) begin
      fails++;
      $display("BAD reading expected %h seen %h count %0d", e,
               (got.size() > 0) ? got[0] : 24'h000000, got.size());
    end
    got.delete();
  endtask : chk_rdg

  task automatic chk_none();
    chk32("reading count", 32'h0, 32'(got.size()));
    got.delete();
  endtask : chk_none

  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] ad, output logic [31:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask : rd_reg

  task automatic send(input int v);
    int n;
    @(posedge mclk);
    go <= 1'b1;
    val <= v[23:0];
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; n < 100 && conv.valid !== 1'b1; n++) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask : send

  function automatic logic [31:0] cfg(input logic lp, input logic df,
      input logic rpt, input logic [6:0] cnt, input logic [9:0] win);
    return {6'h00, win, 5'h00, cnt, rpt, df, lp, 1'b0};
  endfunction : cfg

  function automatic logic [23:0] avg(input int s, input int n);
    int q;
    q = s / n;
    return q[23:0];
  endfunction : avg

  initial begin
    void'($urandom(82));
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    rd_reg(8'h20, d);
    chk32("config reset", 32'h000100A4, d);
    wr_reg(wfa_pkg::A_FS, 32'h00002710);
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b0, 7'h02, 10'h000));
    wr_reg(wfa_pkg::A_KEY, 32'h00000000);
    rd_reg(wfa_pkg::A_STAT, d);
    chk32("enable", 32'h1, 32'(d[wfa_pkg::S_EN]));
    send(100);
    chk_none();
    send(301);
    chk_rdg(avg(401, 2));
    send(-501);
    chk_rdg(avg(-200, 2));
    rd_reg(wfa_pkg::A_STAT, d);
    chk32("event set", 32'h1, 32'(d[wfa_pkg::S_OPEV]));
    rd_reg(wfa_pkg::A_STAT, d);
    chk32("event clear", 32'h0, 32'(d[wfa_pkg::S_OPEV]));
    // Random stream through a two-deep moving stack
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b0, 7'h02, 10'h000));
    a = $urandom_range(4000) - 2000;
    send(a);
    got.delete();
    repeat (16) begin
      b = $urandom_range(4000) - 2000;
      send(b);
      chk_rdg(avg(a + b, 2));
      a = b;
    end
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b1, 7'h03, 10'h000));
    send(3);
    send(6);
    send(9);
    chk_rdg(24'd6);
    send(12);
    chk_none();
    send(15);
    send(18);
    chk_rdg(24'd15);
    // Count one, 1 percent of a 10000 range: half width 100
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b0, 7'h01, 10'h064));
    send(1000);
    chk_rdg(24'd1000);
    send(1100);
    chk_rdg(24'd1100);
    send(1201);
    chk_none();
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b0, 7'h04, 10'h064));
    for (x = 0; x < 4; x++) send(1000);
    chk_rdg(24'd1000);
    chk32("settled", 32'h1, 32'(settled));
    send(5000);
    chk_rdg(24'd5000);
    send(5040);
    chk_rdg(avg(3 * 5000 + 5040, 4));
    chk32("unsettled", 32'h0, 32'(settled));
    // Analog stage holds off the next conversion
    wr_reg(8'h20, cfg(1'b1, 1'b1, 1'b0, 7'h01, 10'h000));
    @(negedge mclk);
    chk32("analog on", 32'h1, 32'(lpass_on));
    send(7);
    chk_rdg(24'd7);
    repeat (40) @(posedge mclk);
    chk32("settle time", 32'd20, 32'(lowrun));
    // Scan forces repeating even with moving chosen
    wr_reg(wfa_pkg::A_CTRL, 32'h00000010);
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b0, 7'h02, 10'h000));
    send(10);
    send(20);
    chk_rdg(24'd15);
    send(30);
    chk_none();
    // Delta wins over scan and forces moving
    wr_reg(wfa_pkg::A_CTRL, 32'h00000018);
    wr_reg(8'h20, cfg(1'b0, 1'b1, 1'b1, 7'h02, 10'h000));
    send(10);
    send(20);
    chk_rdg(24'd15);
    send(40);
    chk_rdg(24'd30);
    // Ratio on channel two still uses channel one state
    wr_reg(wfa_pkg::A_CTRL, 32'h00000005);
    rd_reg(wfa_pkg::A_STAT, d);
    chk32("ratio enable", 32'h1, 32'(d[wfa_pkg::S_EN]));
    // Temperature window from thermocouple maximum 20000: half width 200
    wr_reg(wfa_pkg::A_CTRL, 32'h00000002);
    wr_reg(wfa_pkg::A_TCMAX, 32'h00004E20);
    wr_reg(8'h28, cfg(1'b0, 1'b1, 1'b0, 7'h01, 10'h064));
    wr_reg(wfa_pkg::A_KEY, 32'h00000000);
    send(1000);
    chk_rdg(24'd1000);
    send(1150);
    chk_rdg(24'd1150);
    wr_reg(wfa_pkg::A_KEY, 32'h00000000);
    repeat (10) @(posedge mclk);
    chk32("indicator off", 32'h0, 32'(indicator));
    rd_reg(wfa_pkg::A_STAT, d);
    chk32("disabled", 32'h0, 32'(d[wfa_pkg::S_EN]));
    conclude();
  end
endmodule : windowed_averaging_reading_filter_bench
